// ### hw/cbst_osc_tick.v
`timescale 1ns/1ps
`include "cbst_regs.vh"
// Fractional divider: one pulse per oscillator cycle, averaged at 6 MHz
module cbst_osc_tick (
   input  wire CORE_CLK,
   input  wire RST,
   output reg  osc_tick
);
   reg [`CBST_OSC_ACC_W-1:0] acc;
   wire [`CBST_OSC_ACC_W:0]  sum;
   wire [`CBST_OSC_ACC_W:0]  wrapped;

   // Sized constants keep the accumulator arithmetic at its own width
   assign sum     = {1'b0, acc} + `CBST_OSC_INC;
   assign wrapped = sum - `CBST_OSC_WRAP;

   ////////////////////////////////////////////////////////////////////////
   // Phase accumulator; core clock is not a multiple of the oscillator
   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         acc      <= {`CBST_OSC_ACC_W{1'b0}};
         osc_tick <= 1'b0;
      end else if (sum >= `CBST_OSC_WRAP) begin
         acc      <= wrapped[`CBST_OSC_ACC_W-1:0];
         osc_tick <= 1'b1;
      end else begin
         acc      <= sum[`CBST_OSC_ACC_W-1:0];
         osc_tick <= 1'b0;
      end
   end
endmodule // cbst_osc_tick

// ### hw/cbst_ramp.v
`timescale 1ns/1ps
`include "cbst_regs.vh"
// Output current ramp: one 10 mA code step per step time
module cbst_ramp (
   input  wire       CORE_CLK,
   input  wire       RST,
   input  wire       osc_tick,
   input  wire       enable,
   input  wire       starting,
   input  wire [2:0] start_rate,
   input  wire [2:0] def_rate,
   input  wire [7:0] target,
   output reg  [7:0] level,
   output reg        ramping
);
   reg  [10:0] step_cnt;
   wire [2:0]  rate;
   wire [3:0]  expo;
   wire [10:0] period;

   // Codes below the floor are raised so the step never gets too fast
   assign rate   = starting ? start_rate : def_rate;
   assign expo   = (rate < `CBST_SLEW_MIN) ? {1'b0, `CBST_SLEW_MIN} : {1'b0, rate}; // see R3
   assign period = 11'h001 << expo; // see R2

   ////////////////////////////////////////////////////////////////////////
   // Step counter in oscillator cycles, one code (10 mA) per step
   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         step_cnt <= 11'h000;
         level    <= 8'h00;
         ramping  <= 1'b0;
      end else if (!enable) begin
         step_cnt <= 11'h000;
         level    <= 8'h00;
         ramping  <= 1'b0;
      end else begin
         ramping <= (level != target);
         if (level == target) begin
            step_cnt <= 11'h000;
         end else if (osc_tick) begin // see R4
            if (step_cnt >= period - 11'h001) begin
               step_cnt <= 11'h000;
               level    <= (level < target) ? level + 8'h01 : level - 8'h01; // see R2
            end else begin
               step_cnt <= step_cnt + 11'h001;
            end
         end
      end
   end
endmodule // cbst_ramp

// ### hw/cbst_regs.vh
`ifndef CBST_REGS_VH
`define CBST_REGS_VH
// Register offsets
`define CBST_ADDR_W          9
`define CBST_OFS_SLEW        9'h00A
`define CBST_OFS_TMRTEMP     9'h00B
`define CBST_OFS_COUNT       9'h00C
`define CBST_OFS_PRELOAD     9'h00D
`define CBST_OFS_ENABLE      9'h00E
`define CBST_OFS_PEAK        9'h00F
`define CBST_OFS_IOUT        9'h010
// Field layout
`define CBST_START_SLEW_HI   6
`define CBST_START_SLEW_LO   4
`define CBST_DEF_SLEW_HI     2
`define CBST_DEF_SLEW_LO     0
`define CBST_TMR_OFF_BIT     4
`define CBST_TEMP_HI         3
`define CBST_TEMP_LO         0
`define CBST_PEAK_HI         4
`define CBST_PEAK_LO         0
// Reset values
`define CBST_RST_SLEW        8'h55
`define CBST_RST_TMRTEMP     8'h00
`define CBST_RST_PRELOAD     8'hFF
`define CBST_RST_PEAK        5'h00
`define CBST_RST_IOUT        8'h0F
// Limits and encodings
`define CBST_PEAK_MAX        5'h19
`define CBST_IOUT_MAX        8'hE1
`define CBST_IOUT_MIN        8'h0F
`define CBST_SLEW_MIN        3'h5
`define CBST_TEMP_BASE_C     8'h46
`define CBST_TEMP_STEP_C     8'h05
// Timing: core clock 40 MHz, oscillator 6 MHz, seconds tick
`define CBST_CLK_HZ          40000000
`define CBST_OSC_HZ          6000000
`define CBST_SECOND_S        1
`define CBST_SEC_CYCLES      (`CBST_CLK_HZ * `CBST_SECOND_S)
`define CBST_OSC_ACC_W       27
`define CBST_OSC_INC         28'h05B8D80
`define CBST_OSC_WRAP        28'h2625A00
`endif

// ### hw/cbst_top.v
`timescale 1ns/1ps
`include "cbst_regs.vh"

// Summary of operation
// R1 - The start ramp rate sits in bits 6 to 4 with the same coding as the default rate.
// R2 - Output current moves in 10 mA code steps, each held for two to the power of the rate code oscillator cycles.
// R3 - Rate codes below 5 behave as 5.
// R4 - Steps are timed from the internal oscillator, 6 MHz nominal.
// R5 - Bit 4 set turns the safety countdown off, clear keeps it on.
// R6 - The warning threshold is 70 degrees plus 5 per code of bits 3 to 0.
// R7 - The eight-bit countdown drops by one each second while running.
// R8 - Reading the countdown register returns the live count and writes to it are ignored.
// R9 - A preload written while the converter is off is copied into the countdown at the next enable.
// R10 - A preload written while the converter runs goes straight into the countdown.
// R11 - The preload is whole seconds 0 to 255 and resets to 0xFF.
// R12 - The converter enable bit follows enable pin edges and may also be written.
// R13 - Peak limit code is 3000 mA plus 100 mA per code, stored as written, clamped to 0x19 at the output.
// R14 - Output current code is 250 mA plus 10 mA per code from 0x0F, clamped to 0xE1 at the output.
// R15 - Countdown expiry raises the timer event.
// R16 - Counting runs only while enabled and not turned off, and stops at zero.
module cbst_top #(
   parameter SEC_CYCLES = `CBST_SEC_CYCLES
) (
   input  wire                    CORE_CLK,
   input  wire                    RST,
   input  wire                    EN_PIN,
   input  wire                    REG_WR,
   input  wire                    REG_RD,
   input  wire [`CBST_ADDR_W-1:0] REG_ADDR,
   input  wire [7:0]              REG_WDATA,
   output reg  [7:0]              REG_RDATA,
   output reg                     REG_RVALID,
   output reg                     CONVERTER_ON,
   output reg  [4:0]              PEAK_LIMIT_OUT,
   output reg  [7:0]              OUTPUT_CURRENT_OUT,
   output reg  [7:0]              RAMP_LEVEL,
   output reg                     RAMPING,
   output reg  [7:0]              TEMP_WARNING_C,
   output reg                     TIMER_EVENT
);

   ////////////////////////////////////////////////////////////////////////
   // Storage
   reg  [7:0]  slew_rate_config;
   reg  [7:0]  timer_disable_and_temp_warning;
   reg  [7:0]  safety_countdown;
   reg  [7:0]  safety_preload;
   reg  [4:0]  peak_limit_code;
   reg  [7:0]  output_current_code;
   reg         en_pin_d;
   reg         on_d;
   reg         starting;
   reg  [25:0] sec_cnt;
   reg  [7:0]  next_countdown;
   reg         next_on;
   reg  [7:0]  next_rdata;

   wire        osc_tick;
   wire [7:0]  ramp_level;
   wire        ramp_busy;
   wire        wr_slew;
   wire        wr_tmrtemp;
   wire        wr_preload;
   wire        wr_enable;
   wire        wr_peak;
   wire        wr_iout;
   wire        safety_countdown_off;
   wire        counting;
   wire        sec_tick;
   wire [7:0]  iout_clamped;
   wire [7:0]  peak_clamped;
   wire [2:0]  default_ramp_rate;
   wire [2:0]  start_ramp_rate;
   wire [3:0]  temp_warning_threshold;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function wr_hit;
      input [`CBST_ADDR_W-1:0] ofs;
      begin
         wr_hit = REG_WR && (REG_ADDR == ofs);
      end
   endfunction

   // Clamp a code to its maximum; shared by the two current fields
   function [7:0] clamp8;
      input [7:0] val;
      input [7:0] max;
      begin
         clamp8 = (val > max) ? max : val;
      end
   endfunction

   assign wr_slew    = wr_hit(`CBST_OFS_SLEW);
   assign wr_tmrtemp = wr_hit(`CBST_OFS_TMRTEMP);
   assign wr_preload = wr_hit(`CBST_OFS_PRELOAD);
   assign wr_enable  = wr_hit(`CBST_OFS_ENABLE);
   assign wr_peak    = wr_hit(`CBST_OFS_PEAK);
   assign wr_iout    = wr_hit(`CBST_OFS_IOUT);

   assign start_ramp_rate   = slew_rate_config[`CBST_START_SLEW_HI:`CBST_START_SLEW_LO]; // see R1
   assign default_ramp_rate = slew_rate_config[`CBST_DEF_SLEW_HI:`CBST_DEF_SLEW_LO];
   assign safety_countdown_off = timer_disable_and_temp_warning[`CBST_TMR_OFF_BIT]; // see R5
   assign temp_warning_threshold =
      timer_disable_and_temp_warning[`CBST_TEMP_HI:`CBST_TEMP_LO];
   // Below-minimum codes pass unchanged; floor is the host's concern
   assign iout_clamped = clamp8(output_current_code, `CBST_IOUT_MAX); // see R14
   assign peak_clamped = clamp8({3'b000, peak_limit_code}, {3'b000, `CBST_PEAK_MAX}); // see R13

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers, reserved bits forced to zero
   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         slew_rate_config               <= `CBST_RST_SLEW;
         timer_disable_and_temp_warning <= `CBST_RST_TMRTEMP;
         peak_limit_code                <= `CBST_RST_PEAK;
         output_current_code            <= `CBST_RST_IOUT;
         safety_preload                 <= `CBST_RST_PRELOAD; // see R11
      end else begin
         if (wr_slew)
            slew_rate_config <= REG_WDATA & 8'h77;
         if (wr_tmrtemp)
            timer_disable_and_temp_warning <= REG_WDATA & 8'h1F;
         if (wr_peak)
            peak_limit_code <= REG_WDATA[`CBST_PEAK_HI:`CBST_PEAK_LO]; // see R13
         if (wr_iout)
            output_current_code <= REG_WDATA; // see R14
         if (wr_preload)
            safety_preload <= REG_WDATA; // see R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter enable: pin edges beat a same-cycle software write
   always @* begin
      next_on = CONVERTER_ON;
      if (wr_enable)
         next_on = REG_WDATA[0];
      if (EN_PIN && !en_pin_d)
         next_on = 1'b1; // see R12
      else if (!EN_PIN && en_pin_d)
         next_on = 1'b0; // see R12
   end

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         en_pin_d     <= 1'b0;
         CONVERTER_ON <= 1'b0;
         on_d         <= 1'b0;
         starting     <= 1'b0;
      end else begin
         en_pin_d     <= EN_PIN;
         CONVERTER_ON <= next_on;
         on_d         <= CONVERTER_ON;
         // Start rate applies until the first ramp after enable settles
         if (CONVERTER_ON && !on_d)
            starting <= 1'b1;
         else if (!CONVERTER_ON || (on_d && !ramp_busy && !RAMPING))
            starting <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Seconds prescaler, restarted whenever counting stops
   assign counting = CONVERTER_ON && !safety_countdown_off && (safety_countdown != 8'h00); // see R16
   assign sec_tick = counting && (sec_cnt == SEC_CYCLES - 1);

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         sec_cnt <= 26'h0000000;
      else if (!counting || sec_tick)
         sec_cnt <= 26'h0000000;
      else
         sec_cnt <= sec_cnt + 26'h0000001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Countdown: load on enable edge or running write, else tick down
   always @* begin
      next_countdown = safety_countdown;
      if (sec_tick)
         next_countdown = safety_countdown - 8'h01; // see R7
      if (CONVERTER_ON && !on_d)
         next_countdown = safety_preload; // see R9
      if (wr_preload && CONVERTER_ON)
         next_countdown = REG_WDATA; // see R10
   end

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         safety_countdown <= 8'h00;
         TIMER_EVENT      <= 1'b0;
      end else begin
         safety_countdown <= next_countdown;
         // Pulse on the tick that reaches zero
         TIMER_EVENT <= sec_tick && (safety_countdown == 8'h01); // see R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ramp engine and oscillator tick
   cbst_osc_tick u_osc (
      .CORE_CLK (CORE_CLK),
      .RST      (RST),
      .osc_tick (osc_tick)
   );

   cbst_ramp u_ramp (
      .CORE_CLK   (CORE_CLK),
      .RST        (RST),
      .osc_tick   (osc_tick),
      .enable     (CONVERTER_ON),
      .starting   (starting),
      .start_rate (start_ramp_rate),
      .def_rate   (default_ramp_rate),
      .target     (iout_clamped),
      .level      (ramp_level),
      .ramping    (ramp_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs registered
   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         PEAK_LIMIT_OUT     <= `CBST_RST_PEAK;
         OUTPUT_CURRENT_OUT <= `CBST_RST_IOUT;
         RAMP_LEVEL         <= 8'h00;
         RAMPING            <= 1'b0;
         TEMP_WARNING_C     <= `CBST_TEMP_BASE_C;
      end else begin
         PEAK_LIMIT_OUT     <= peak_clamped[`CBST_PEAK_HI:`CBST_PEAK_LO]; // see R13
         OUTPUT_CURRENT_OUT <= iout_clamped; // see R14
         RAMP_LEVEL         <= ramp_level;
         RAMPING            <= ramp_busy;
         // 70 + 5*N degrees, at most 145
         TEMP_WARNING_C     <= `CBST_TEMP_BASE_C
                               + {4'h0, temp_warning_threshold} * `CBST_TEMP_STEP_C; // see R6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped offsets read zero
   always @* begin
      case (REG_ADDR)
         `CBST_OFS_SLEW:    next_rdata = slew_rate_config;
         `CBST_OFS_TMRTEMP: next_rdata = timer_disable_and_temp_warning;
         `CBST_OFS_COUNT:   next_rdata = safety_countdown; // see R8
         `CBST_OFS_PRELOAD: next_rdata = safety_preload;
         `CBST_OFS_ENABLE:  next_rdata = {7'h00, CONVERTER_ON};
         `CBST_OFS_PEAK:    next_rdata = {3'b000, peak_limit_code};
         `CBST_OFS_IOUT:    next_rdata = output_current_code;
         default:           next_rdata = 8'h00;
      endcase
   end

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD)
            REG_RDATA <= next_rdata;
      end
   end

endmodule // cbst_top

// ### verif/cbst_host_model.sv
`timescale 1ns/1ps
// Host side of the serial front end: one-cycle strobes at falling edges
module cbst_host_model (
   input  wire        CORE_CLK,
   input  wire [7:0]  REG_RDATA,
   input  wire        REG_RVALID,
   output logic       REG_WR,
   output logic       REG_RD,
   output logic [8:0] REG_ADDR,
   output logic [7:0] REG_WDATA
);
   initial begin
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 9'h1FF;
      REG_WDATA = 8'h00;
   end
   // Released address and data are inverted so stale values never match
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge CORE_CLK);
      REG_WR = 1'b1;
      REG_ADDR = a;
      REG_WDATA = d;
      @(negedge CORE_CLK);
      REG_WR = 1'b0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
   endtask
   task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic v);
      @(negedge CORE_CLK);
      REG_RD = 1'b1;
      REG_ADDR = a;
      @(negedge CORE_CLK);
      REG_RD = 1'b0;
      REG_ADDR = ~a;
      d = REG_RDATA;
      v = REG_RVALID;
   endtask
endmodule // cbst_host_model

// ### verif/cbst_sva.sv
`timescale 1ns/1ps
// Port-level checks of the buck control register bank
module cbst_sva #(
   parameter SEC_CYCLES = 40000000
) (
   input wire       CORE_CLK,
   input wire       RST,
   input wire       EN_PIN,
   input wire       REG_WR,
   input wire       REG_RD,
   input wire [8:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire [7:0] REG_RDATA,
   input wire       REG_RVALID,
   input wire       CONVERTER_ON,
   input wire [4:0] PEAK_LIMIT_OUT,
   input wire [7:0] OUTPUT_CURRENT_OUT,
   input wire [7:0] RAMP_LEVEL,
   input wire       RAMPING,
   input wire [7:0] TEMP_WARNING_C,
   input wire       TIMER_EVENT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////
   // Register access, one-cycle answer and held data
   chk_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read strobe not answered");
   chk_rvalid_cause: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("read answer without strobe");
   chk_rdata_hold: assert property (!REG_RVALID |-> $stable(REG_RDATA))
      else $error("read data moved without answer");
   // Peak and warning outputs follow writes two edges later; current output stays at or below 0xE1
   chk_peak_follow: assert property (REG_WR && REG_ADDR == 9'h00F |-> ##2
      PEAK_LIMIT_OUT == (($past(REG_WDATA[4:0], 2) > 5'h19) ? 5'h19 : $past(REG_WDATA[4:0], 2)))
      else $error("peak limit output wrong");
   chk_iout_clamp: assert property (OUTPUT_CURRENT_OUT <= 8'hE1)
      else $error("output current above maximum");
   chk_temp_follow: assert property (REG_WR && REG_ADDR == 9'h00B |-> ##2
      TEMP_WARNING_C == 8'h46 + 8'h05 * $past(REG_WDATA[3:0], 2))
      else $error("warning threshold wrong");
   // Pin edges drive the enable bit
   chk_pin_rise: assert property ($rose(EN_PIN) |-> ##[1:2] CONVERTER_ON)
      else $error("enable pin rise missed");
   chk_pin_fall: assert property ($fell(EN_PIN) |-> ##[1:2] !CONVERTER_ON)
      else $error("enable pin fall missed");
   // Expiry only while running, single pulse
   chk_event_cause: assert property (TIMER_EVENT |->
      $past(CONVERTER_ON) && !$past(TIMER_EVENT)) else $error("timer event out of place");
   // Ramp moves one code at a time once settled on
   chk_ramp_step: assert property ($past(CONVERTER_ON, 2) && CONVERTER_ON |->
      RAMP_LEVEL == $past(RAMP_LEVEL) || RAMP_LEVEL == $past(RAMP_LEVEL) + 8'h01
      || RAMP_LEVEL + 8'h01 == $past(RAMP_LEVEL)) else $error("ramp jumped");
   cover property (TIMER_EVENT);
   cover property ($rose(EN_PIN));
   cover property ($fell(RAMPING));
endmodule // cbst_sva

bind cbst_top cbst_sva #(.SEC_CYCLES(SEC_CYCLES)) i_sva (.CORE_CLK(CORE_CLK), .RST(RST),
   .EN_PIN(EN_PIN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .CONVERTER_ON(CONVERTER_ON), .PEAK_LIMIT_OUT(PEAK_LIMIT_OUT),
   .OUTPUT_CURRENT_OUT(OUTPUT_CURRENT_OUT), .RAMP_LEVEL(RAMP_LEVEL), .RAMPING(RAMPING),
   .TEMP_WARNING_C(TEMP_WARNING_C), .TIMER_EVENT(TIMER_EVENT));

// ### verif/cbst_tb.sv
`timescale 1ns/1ps
module testbench;
   localparam int SEC = 200;
   logic       core_clk, rst, en_pin;
   wire        wr, rd, rvalid, on, ramping, tevent;
   wire  [8:0] addr;
   wire  [7:0] wdata, rdata, iout, ramp;
   wire  [4:0] peak;
   wire  [7:0] temp;
   int         errors = 0, total_checks = 0, n;
   logic [7:0] rst_val [7] = '{8'h55, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0F};
   logic [7:0] rw_mask [7] = '{8'h77, 8'h1F, 8'h00, 8'hFF, 8'h01, 8'h1F, 8'hFF};

   cbst_top #(.SEC_CYCLES(SEC)) i_dut (.CORE_CLK(core_clk), .RST(rst), .EN_PIN(en_pin),
      .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .CONVERTER_ON(on), .PEAK_LIMIT_OUT(peak),
      .OUTPUT_CURRENT_OUT(iout), .RAMP_LEVEL(ramp), .RAMPING(ramping),
      .TEMP_WARNING_C(temp), .TIMER_EVENT(tevent));
   cbst_host_model i_host (.CORE_CLK(core_clk), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata));

   ////////////////////////////////////////////////////////////////////////
   // Clock, 25 ns period
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic check(string what, logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // Missing answer poisons the data so the compare fails
   task automatic rchk(logic [8:0] a, logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      i_host.rd(a, d, v);
      if (v !== 1'b1) d = 'x;
      check("read data", d, exp);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the roughly 8400 cycles the tests need
   initial begin
      repeat (40000) @(posedge core_clk);
      errors++;
      $display("unexpected timeout: expected finish seen hang");
      final_report;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      en_pin = 1'b0;
      rst = 1'b1;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      // Reset values, then all-ones writes to find reserved and read-only bits
      for (int i = 0; i < 7; i++) rchk(9'h00A + i, rst_val[i]);
      for (int i = 0; i < 7; i++) begin
         i_host.wr(9'h00A + i, 8'hFF);
         rchk(9'h00A + i, rw_mask[i]);
      end
      rchk(9'h011, 8'h00);
      check("peak clamp", {3'b0, peak}, 8'h19);
      check("iout clamp", iout, 8'hE1);
      check("enable by write", {7'b0, on}, 8'h01);
      i_host.wr(9'h00F, 8'h18);
      i_host.wr(9'h010, 8'h20);
      i_host.wr(9'h00E, 8'h00);
      @(negedge core_clk);
      check("peak code", {3'b0, peak}, 8'h18);
      check("iout code", iout, 8'h20);
      check("disable by write", {7'b0, on}, 8'h00);
      // Every warning code; bit 4 stays clear so the timer is enabled
      for (int k = 0; k < 16; k++) begin
         i_host.wr(9'h00B, 8'(k));
         @(negedge core_clk);
         check("threshold", temp, 8'h46 + 8'h05 * 8'(k));
      end
      // Preload while off, copy on pin rise, reload while running
      i_host.wr(9'h00D, 8'h03);
      rchk(9'h00C, 8'hFF);
      en_pin = 1'b1;
      repeat (3) @(negedge core_clk);
      check("enable by pin", {7'b0, on}, 8'h01);
      rchk(9'h00C, 8'h03);
      i_host.wr(9'h00D, 8'h02);
      rchk(9'h00C, 8'h02);
      i_host.wr(9'h00C, 8'h55);
      rchk(9'h00C, 8'h02);
      n = 0;
      while (tevent !== 1'b1 && n < 3 * SEC) begin
         @(negedge core_clk);
         n++;
      end
      check("expiry time", 8'(n >= SEC - 10 && n <= 2 * SEC), 8'h01);
      repeat (2 * SEC) @(negedge core_clk);
      rchk(9'h00C, 8'h00);
      en_pin = 1'b0;
      repeat (3) @(negedge core_clk);
      check("disable by pin", {7'b0, on}, 8'h00);
      // Rate codes 0 act as 5: 32 steps of 32 oscillator cycles, about 6827 clocks
      i_host.wr(9'h00A, 8'h00);
      i_host.wr(9'h00B, 8'h10);
      en_pin = 1'b1;
      n = 0;
      while (ramp !== 8'h20 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
      check("ramp time", 8'(n > 6480 && n < 7170), 8'h01);
      i_host.wr(9'h00D, 8'h05);
      repeat (3 * SEC) @(negedge core_clk);
      rchk(9'h00C, 8'h05);
      check("ramp settled", {7'b0, ramping}, 8'h00);
      en_pin = 1'b0;
      repeat (3) @(negedge core_clk);
      final_report;
   end
endmodule // testbench
